// file: design/outsel_pkg.sv
/*
 * Constants and codes for the output terminal selector.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package outsel_pkg;

	localparam int ADDR_W = 8;
	localparam int SEL_W = 16;
	localparam int NUM_COND = 27;
	localparam int IDX_W = 5;

	localparam logic [ADDR_W-1:0] SEL_A_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] SEL_RELAY_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] SEL_B_ADDR = 8'h08;
	localparam logic [ADDR_W-1:0] EXT_DISP_ADDR = 8'h0c;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h10;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h14;

	localparam logic [SEL_W-1:0] SEL_A_RST = 16'h0000;
	localparam logic [SEL_W-1:0] SEL_RELAY_RST = 16'h0063;
	localparam logic [SEL_W-1:0] SEL_B_RST = 16'h0050;
	localparam logic [SEL_W-1:0] EXT_DISP_RST = 16'h0000;

	localparam logic [SEL_W-1:0] NEG_OFFSET = 16'd100;
	localparam logic [SEL_W-1:0] CODE_LIMIT = 16'd200;
	localparam logic [SEL_W-1:0] CODE_NONE = 16'd9999;
	localparam logic [SEL_W-1:0] CODE_AVG_PULSE = 16'd93;

	// control register bits (write one to act)
	localparam int CTRL_PL_RELEASE = 0;
	localparam int CTRL_CLR_REFUSED = 1;
	// status register bits
	localparam int ST_TERM_LSB = 0;
	localparam int ST_REFUSED = 3;
	localparam int ST_PL_LATCH = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TERM_A = 2'h0,
		TERM_RELAY = 2'h1,
		TERM_B = 2'h2
	} term_t;

endpackage

// file: design/output_terminal_signal_select.sv
/*
 * Output terminal selector: three terminals, each driven by a status
 * condition chosen through a software selection register, with polarity.
 * Only listed codes are stored, so the terminals never decode garbage.
 * Assumes status inputs come from logic on the same clock and an
 * AXI4-Lite master that keeps at most one write and one read in flight.
 */
`timescale 1ns/1ps
`default_nettype none

module output_terminal_signal_select
	import outsel_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic drive_running,
	input wire logic target_freq_reached,
	input wire logic overload_warning,
	input wire logic freq_threshold_hit,
	input wire logic regen_duty_prealarm,
	input wire logic thermal_prealarm,
	input wire logic drive_prepared,
	input wire logic overcurrent_detect,
	input wire logic zero_current_detect,
	input wire logic loop_low_limit,
	input wire logic loop_high_limit,
	input wire logic loop_forward_dir,
	input wire logic fan_fault,
	input wire logic heatsink_prealarm,
	input wire logic powerloss_decel_start,
	input wire logic loop_regulation_active,
	input wire logic retry_active,
	input wire logic loop_sleep,
	input wire logic safe_stop_active,
	input wire logic safe_circuit_ok,
	input wire logic life_alarm,
	input wire logic hard_fault,
	input wire logic current_avg_pulse,
	input wire logic maint_timer_due,
	input wire logic remote_out,
	input wire logic warn_alarm,
	input wire logic fault_flag,
	output logic open_drain_a_on,
	output logic relay_on,
	output logic open_drain_b_on
);

	logic [SEL_W-1:0] sel_a_ff, sel_relay_ff, sel_b_ff, ext_disp_ff;
	logic [SEL_W-1:0] nxt_sel_a, nxt_sel_relay, nxt_sel_b, nxt_ext_disp;
	logic refused_ff, nxt_refused;
	logic pl_latch_ff, nxt_pl_latch;
	logic aw_ff, nxt_aw, w_ff, nxt_w;
	logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [2:0] term_ff, nxt_term;
	logic [NUM_COND-1:0] cond;
	logic [SEL_W-1:0] sel_arr [3];

	logic aw_hs, w_hs, ar_hs, do_wr;
	logic [ADDR_W-1:0] cur_addr;
	logic [31:0] cur_data;
	logic [3:0] cur_strb;

	// condition vector, ordered as the index map of cond_lookup
	assign cond = {
		fault_flag,
		warn_alarm,
		remote_out,
		maint_timer_due,
		current_avg_pulse,
		hard_fault,
		life_alarm,
		safe_circuit_ok,
		safe_stop_active,
		loop_sleep,
		retry_active,
		loop_regulation_active,
		pl_latch_ff,
		heatsink_prealarm,
		fan_fault,
		loop_forward_dir,
		loop_high_limit,
		loop_low_limit,
		zero_current_detect,
		overcurrent_detect,
		drive_prepared,
		thermal_prealarm,
		regen_duty_prealarm,
		freq_threshold_hit,
		overload_warning,
		target_freq_reached,
		drive_running
	};

	assign sel_arr[0] = sel_a_ff;
	assign sel_arr[1] = sel_relay_ff;
	assign sel_arr[2] = sel_b_ff;

	// one response outstanding at a time, so both address and data stall
	assign awready = !aw_ff && !bvalid_ff;
	assign wready = !w_ff && !bvalid_ff;
	assign arready = !rvalid_ff;
	assign aw_hs = awvalid && awready;
	assign w_hs = wvalid && wready;
	assign ar_hs = arvalid && arready;
	assign do_wr = (aw_ff || aw_hs) && (w_ff || w_hs);
	assign cur_addr = aw_ff ? awaddr_ff : awaddr;
	assign cur_data = w_ff ? wdata_ff : wdata;
	assign cur_strb = w_ff ? wstrb_ff : wstrb;

	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rresp = rresp_ff;
	assign rdata = rdata_ff;
	assign open_drain_a_on = term_ff[TERM_A];
	assign relay_on = term_ff[TERM_RELAY];
	assign open_drain_b_on = term_ff[TERM_B];

	// upper byte lanes are dropped: every register is 16 bits wide
	function automatic logic [SEL_W-1:0] merge16(input logic [SEL_W-1:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// maps a positive-logic code to its condition index; bit 5 flags a hit
	function automatic logic [IDX_W:0] cond_lookup(input logic [SEL_W-1:0] b);
		case (b)
			16'd0: cond_lookup = {1'b1, 5'd0};
			16'd1: cond_lookup = {1'b1, 5'd1};
			16'd3: cond_lookup = {1'b1, 5'd2};
			16'd4: cond_lookup = {1'b1, 5'd3};
			16'd7: cond_lookup = {1'b1, 5'd4};
			16'd8: cond_lookup = {1'b1, 5'd5};
			16'd11: cond_lookup = {1'b1, 5'd6};
			16'd12: cond_lookup = {1'b1, 5'd7};
			16'd13: cond_lookup = {1'b1, 5'd8};
			16'd14: cond_lookup = {1'b1, 5'd9};
			16'd15: cond_lookup = {1'b1, 5'd10};
			16'd16: cond_lookup = {1'b1, 5'd11};
			16'd25: cond_lookup = {1'b1, 5'd12};
			16'd26: cond_lookup = {1'b1, 5'd13};
			16'd46: cond_lookup = {1'b1, 5'd14};
			16'd47: cond_lookup = {1'b1, 5'd15};
			16'd64: cond_lookup = {1'b1, 5'd16};
			16'd70: cond_lookup = {1'b1, 5'd17};
			16'd80: cond_lookup = {1'b1, 5'd18};
			16'd81: cond_lookup = {1'b1, 5'd19};
			16'd90: cond_lookup = {1'b1, 5'd20};
			16'd91: cond_lookup = {1'b1, 5'd21};
			16'd93: cond_lookup = {1'b1, 5'd22};
			16'd95: cond_lookup = {1'b1, 5'd23};
			16'd96: cond_lookup = {1'b1, 5'd24};
			16'd98: cond_lookup = {1'b1, 5'd25};
			16'd99: cond_lookup = {1'b1, 5'd26};
			default: cond_lookup = '0;
		endcase
	endfunction

	// negative-logic codes fold onto the positive table
	function automatic logic [SEL_W-1:0] base_code(input logic [SEL_W-1:0] c);
		base_code = (c >= NEG_OFFSET) ? c - NEG_OFFSET : c;
	endfunction

	function automatic logic code_legal(input logic [SEL_W-1:0] c,
		input term_t t);
		logic [IDX_W:0] hit;
		hit = cond_lookup(base_code(c));
		// 9999 first: folded by base_code it would miss the table
		if (c == CODE_NONE)
			code_legal = (t != TERM_B);
		else if (c >= CODE_LIMIT || !hit[IDX_W])
			code_legal = 1'b0;
		else if (t == TERM_RELAY && base_code(c) == CODE_AVG_PULSE)
			code_legal = 1'b0;
		else
			code_legal = 1'b1;
	endfunction

	// write side
	always_comb begin
		logic [SEL_W-1:0] m;
		logic refuse;
		logic err;
		m = merge16('0, 32'h0000_0000, 4'h0);
		refuse = 1'b0;
		err = 1'b0;
		nxt_sel_a = sel_a_ff;
		nxt_sel_relay = sel_relay_ff;
		nxt_sel_b = sel_b_ff;
		nxt_ext_disp = ext_disp_ff;
		nxt_aw = aw_ff;
		nxt_w = w_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff && !bready;
		nxt_bresp = bresp_ff;
		nxt_refused = refused_ff;
		nxt_pl_latch = pl_latch_ff;
		if (aw_hs) begin
			nxt_aw = 1'b1;
			nxt_awaddr = awaddr;
		end
		if (w_hs) begin
			nxt_w = 1'b1;
			nxt_wdata = wdata;
			nxt_wstrb = wstrb;
		end
		if (do_wr) begin
			nxt_aw = 1'b0;
			nxt_w = 1'b0;
			nxt_bvalid = 1'b1;
			if (cur_addr == SEL_A_ADDR) begin
				m = merge16(sel_a_ff, cur_data, cur_strb);
				if (ext_disp_ff == '0 && code_legal(m, TERM_A))
					nxt_sel_a = m;
				else
					refuse = 1'b1;
			end else if (cur_addr == SEL_RELAY_ADDR) begin
				m = merge16(sel_relay_ff, cur_data, cur_strb);
				if (ext_disp_ff == '0 && code_legal(m, TERM_RELAY))
					nxt_sel_relay = m;
				else
					refuse = 1'b1;
			end else if (cur_addr == SEL_B_ADDR) begin
				m = merge16(sel_b_ff, cur_data, cur_strb);
				if (ext_disp_ff == '0 && code_legal(m, TERM_B))
					nxt_sel_b = m;
				else
					refuse = 1'b1;
			end else if (cur_addr == EXT_DISP_ADDR) begin
				// stays writable, otherwise a nonzero value would lock for good
				nxt_ext_disp = merge16(ext_disp_ff, cur_data, cur_strb);
			end else if (cur_addr == CTRL_ADDR) begin
				if (cur_strb[0] && cur_data[CTRL_CLR_REFUSED])
					nxt_refused = 1'b0;
				if (cur_strb[0] && cur_data[CTRL_PL_RELEASE])
					nxt_pl_latch = 1'b0;
			end else begin
				err = 1'b1;
			end
			nxt_bresp = (refuse || err) ? RESP_SLVERR : RESP_OKAY;
		end
		if (refuse)
			nxt_refused = 1'b1;
		// a deceleration event in the release cycle keeps the latch set
		if (powerloss_decel_start)
			nxt_pl_latch = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_a_ff <= SEL_A_RST;
			sel_relay_ff <= SEL_RELAY_RST;
			sel_b_ff <= SEL_B_RST;
			ext_disp_ff <= EXT_DISP_RST;
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			refused_ff <= 1'b0;
			pl_latch_ff <= 1'b0;
		end else begin
			sel_a_ff <= nxt_sel_a;
			sel_relay_ff <= nxt_sel_relay;
			sel_b_ff <= nxt_sel_b;
			ext_disp_ff <= nxt_ext_disp;
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			refused_ff <= nxt_refused;
			pl_latch_ff <= nxt_pl_latch;
		end
	end

	// read side: data is registered and stands until rready
	always_comb begin
		nxt_rvalid = rvalid_ff && !rready;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (ar_hs) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = RESP_OKAY;
			nxt_rdata = '0;
			if (araddr == SEL_A_ADDR) begin
				nxt_rdata[SEL_W-1:0] = sel_a_ff;
			end else if (araddr == SEL_RELAY_ADDR) begin
				nxt_rdata[SEL_W-1:0] = sel_relay_ff;
			end else if (araddr == SEL_B_ADDR) begin
				nxt_rdata[SEL_W-1:0] = sel_b_ff;
			end else if (araddr == EXT_DISP_ADDR) begin
				nxt_rdata[SEL_W-1:0] = ext_disp_ff;
			end else if (araddr == CTRL_ADDR) begin
				nxt_rdata = '0;
			end else if (araddr == STATUS_ADDR) begin
				nxt_rdata[ST_TERM_LSB +: 3] = term_ff;
				nxt_rdata[ST_REFUSED] = refused_ff;
				nxt_rdata[ST_PL_LATCH] = pl_latch_ff;
			end else begin
				nxt_rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= '0;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	// terminal drive: each terminal picks one bit of the condition vector
	always_comb begin
		logic [IDX_W:0] hit;
		logic invert;
		hit = '0;
		invert = 1'b0;
		for (int i = 0; i < 3; i++) begin
			hit = cond_lookup(base_code(sel_arr[i]));
			invert = sel_arr[i] >= NEG_OFFSET;
			// an unmatched code parks the terminal off, never on
			if (sel_arr[i] == CODE_NONE || !hit[IDX_W])
				nxt_term[i] = 1'b0;
			else
				nxt_term[i] = cond[hit[IDX_W-1:0]] ^ invert;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			term_ff <= 3'h0;
		else
			term_ff <= nxt_term;
	end

endmodule // output_terminal_signal_select

`default_nettype wire

// file: testbench/outsel_checker.sv
/*
 * Port assertions for the output terminal selector.
 * Assumes the master offers write address and data together, full strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module outsel_checker
	import outsel_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic drive_running,
	input wire logic fault_flag,
	input wire logic safe_stop_active,
	input wire logic open_drain_a_on,
	input wire logic relay_on,
	input wire logic open_drain_b_on
);
	logic wr;
	logic ext_nz_ff;
	logic nxt_ext_nz;
	assign wr = awvalid && awready && wvalid && wready;
	// shadow ignores wstrb, so partial writes would mislead it
	always_comb begin
		nxt_ext_nz = ext_nz_ff;
		if (wr && awaddr == EXT_DISP_ADDR)
			nxt_ext_nz = wdata[15:0] != 16'h0000;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ext_nz_ff <= 1'b0;
		else
			ext_nz_ff <= nxt_ext_nz;
	end
	logic in_rst_ff;
	// plain flop: unknown at the first edge, so that edge is skipped
	// while the terminal flops may not yet have seen the reset
	always_ff @(posedge clk)
		in_rst_ff <= !rst_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_reset_a:
	assert property ($rose(rst_n) |=> open_drain_a_on == $past(drive_running))
		else $error("terminal a default wrong");
	a_reset_relay:
	assert property ($rose(rst_n) |=> relay_on == $past(fault_flag))
		else $error("relay default wrong");
	a_reset_b:
	assert property ($rose(rst_n) |=> open_drain_b_on == $past(safe_stop_active))
		else $error("terminal b default wrong");
	a_idle_reset:
	assert property (disable iff (1'b0) !rst_n && in_rst_ff
		|-> !open_drain_a_on && !relay_on && !open_drain_b_on)
		else $error("terminal on in reset");
	a_relay_avg:
	assert property (wr && awaddr == SEL_RELAY_ADDR
		&& wdata[15:0] == CODE_AVG_PULSE |=> bvalid && bresp == RESP_SLVERR)
		else $error("relay took avg code");
	a_b_none:
	assert property (wr && awaddr == SEL_B_ADDR
		&& wdata[15:0] == CODE_NONE |=> bvalid && bresp == RESP_SLVERR)
		else $error("b took none code");
	a_bad_code:
	assert property (wr && awaddr == SEL_A_ADDR
		&& wdata[15:0] == 16'h0002 |=> bvalid && bresp == RESP_SLVERR)
		else $error("unlisted code taken");
	a_ext_lock:
	assert property (wr && awaddr == SEL_A_ADDR && ext_nz_ff
		|=> bvalid && bresp == RESP_SLVERR)
		else $error("write taken while locked");
	a_neg_ok:
	assert property (wr && awaddr == SEL_B_ADDR && wdata[15:0] == 16'h0064
		&& !ext_nz_ff |=> bvalid && bresp == RESP_OKAY)
		else $error("negative code refused");
	c_relay_wr: cover property (wr && awaddr == SEL_RELAY_ADDR);
	c_refused: cover property (bvalid && bresp == RESP_SLVERR);
	c_locked: cover property (wr && ext_nz_ff);
endmodule // outsel_checker
bind output_terminal_signal_select outsel_checker chk_u (.clk, .rst_n,
	.awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bresp, .bvalid,
	.drive_running, .fault_flag, .safe_stop_active, .open_drain_a_on,
	.relay_on, .open_drain_b_on);
`default_nettype wire

// file: testbench/terminal_reader.sv
/*
 * Far-side equipment: a pull-up on each terminal line.
 * Assumes a conducting terminal pulls its line low.
 */
`timescale 1ns/1ps
`default_nettype none
module terminal_reader (
	input wire logic open_drain_a_on,
	input wire logic relay_on,
	input wire logic open_drain_b_on,
	output logic [2:0] line_lvl
);
	// a released line never keeps a stale low, the pull-up wins
	assign line_lvl = ~{open_drain_b_on, relay_on, open_drain_a_on};
endmodule // terminal_reader
`default_nettype wire

// file: testbench/output_terminal_signal_select_tb_top.sv
/*
 * Self-checking bench for the output terminal selector.
 * Assumes the design answers AXI4-Lite and drives terminals by clock.
 */
`timescale 1ns/1ps
`default_nettype none
module output_terminal_signal_select_tb_top
	import outsel_pkg::*;
;
	logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, pl = 0, n;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [25:0] st = '0;
	logic [15:0] c;
	logic awready, wready, bvalid, arready, rvalid, a_on, r_on, b_on;
	logic [1:0] bresp, rresp;
	logic [2:0] lvl;
	int n_errors = 0, checked = 0;
	int codes[26] = '{0, 1, 3, 4, 7, 8, 11, 12, 13,
		14, 15, 16, 25, 26, 47, 64, 70, 80,
		81, 90, 91, 93, 95, 96, 98, 99};
	always #5 clk = ~clk;
	output_terminal_signal_select dut_u (.clk(clk), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .drive_running(st[0]),
		.target_freq_reached(st[1]), .overload_warning(st[2]),
		.freq_threshold_hit(st[3]), .regen_duty_prealarm(st[4]),
		.thermal_prealarm(st[5]), .drive_prepared(st[6]),
		.overcurrent_detect(st[7]), .zero_current_detect(st[8]),
		.loop_low_limit(st[9]), .loop_high_limit(st[10]),
		.loop_forward_dir(st[11]), .fan_fault(st[12]),
		.heatsink_prealarm(st[13]), .loop_regulation_active(st[14]),
		.retry_active(st[15]), .loop_sleep(st[16]),
		.safe_stop_active(st[17]), .safe_circuit_ok(st[18]),
		.life_alarm(st[19]), .hard_fault(st[20]), .current_avg_pulse(st[21]),
		.maint_timer_due(st[22]), .remote_out(st[23]), .warn_alarm(st[24]),
		.fault_flag(st[25]), .powerloss_decel_start(pl),
		.open_drain_a_on(a_on), .relay_on(r_on), .open_drain_b_on(b_on));
	terminal_reader far_u (.open_drain_a_on(a_on), .relay_on(r_on),
		.open_drain_b_on(b_on), .line_lvl(lvl));
	task automatic end_of_test;
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] er);
		logic ad, wd, x, y;
		logic [1:0] r;
		ad = 0;
		wd = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(negedge clk);
			x = awready;
			y = wready;
			@(posedge clk);
			if (x) awvalid <= 0;
			if (y) wvalid <= 0;
			ad |= x;
			wd |= y;
		end while (!(ad && wd));
		do begin
			@(negedge clk);
			x = bvalid;
			r = bresp;
			@(posedge clk);
		end while (!x);
		bready <= 0;
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic x;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(negedge clk);
			x = arready;
			@(posedge clk);
		end while (!x);
		arvalid <= 0;
		do begin
			@(negedge clk);
			x = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
		end while (!x);
		rready <= 0;
		chk(d, ed);
		chk({30'h0, r}, {30'h0, er});
	endtask
	// status changes land on a rising edge, looked at once settled
	task automatic put(input logic [25:0] v);
		@(posedge clk);
		st <= v;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	initial begin
		#400000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		put(26'h2020001);
		chk({29'h0, lvl}, 32'h0);
		rd(SEL_A_ADDR, 32'h0, RESP_OKAY);
		rd(SEL_RELAY_ADDR, 32'h63, RESP_OKAY);
		rd(SEL_B_ADDR, 32'h50, RESP_OKAY);
		for (int i = 0; i < 52; i++) begin
			c = 16'(codes[i % 26] + (i / 26) * 100);
			n = i >= 26;
			wr(SEL_A_ADDR, c, RESP_OKAY);
			wr(SEL_RELAY_ADDR, c, (i % 26 == 21) ? RESP_SLVERR : RESP_OKAY);
			wr(SEL_B_ADDR, c, RESP_OKAY);
			put(26'h1 << (i % 26));
			chk({29'h0, lvl}, {29'h0, n, (i % 26 == 21) ? !n : n, n});
			put(26'h0);
			chk({29'h0, lvl}, {29'h0, {3{!n}}});
		end
		wr(SEL_A_ADDR, 16'h0002, RESP_SLVERR);
		wr(SEL_A_ADDR, 16'h00c8, RESP_SLVERR);
		rd(SEL_A_ADDR, 32'h00c7, RESP_OKAY);
		wr(SEL_B_ADDR, CODE_NONE, RESP_SLVERR);
		wr(SEL_A_ADDR, CODE_NONE, RESP_OKAY);
		put(26'h3ffffff);
		chk({29'h0, lvl}, 32'h7);
		wr(EXT_DISP_ADDR, 16'h0001, RESP_OKAY);
		wr(SEL_A_ADDR, 16'h0000, RESP_SLVERR);
		rd(SEL_A_ADDR, 32'h270f, RESP_OKAY);
		wr(EXT_DISP_ADDR, 16'h0000, RESP_OKAY);
		wr(SEL_A_ADDR, 16'h002e, RESP_OKAY);
		@(posedge clk);
		pl <= 1;
		@(posedge clk);
		pl <= 0;
		put(26'h0);
		chk({29'h0, lvl}, 32'h0);
		rd(STATUS_ADDR, 32'h1f, RESP_OKAY);
		// event held across the whole release write and one edge after it: the latch must stay set
		pl <= 1;
		wr(CTRL_ADDR, 16'h0001, RESP_OKAY);
		pl <= 0;
		put(26'h0);
		chk({29'h0, lvl}, 32'h0);
		wr(CTRL_ADDR, 16'h0001, RESP_OKAY);
		put(26'h0);
		chk({29'h0, lvl}, 32'h1);
		wr(CTRL_ADDR, 16'h0002, RESP_OKAY);
		rd(STATUS_ADDR, 32'h06, RESP_OKAY);
		wr(STATUS_ADDR, 16'h0000, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		// reset in mid-run with relay and b conducting: all must let go
		rst_n <= 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({29'h0, lvl}, 32'h7);
		@(posedge clk);
		rst_n <= 1;
		rd(SEL_A_ADDR, 32'h0, RESP_OKAY);
		rd(SEL_RELAY_ADDR, 32'h63, RESP_OKAY);
		rd(SEL_B_ADDR, 32'h50, RESP_OKAY);
		rd(STATUS_ADDR, 32'h0, RESP_OKAY);
		end_of_test();
	end
endmodule // output_terminal_signal_select_tb_top
`default_nettype wire
